// >>> fnrb_pkg.sv
// register map, field positions and reset values of the synthesizer register bank
package fnrb_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam logic [5:0] ADDR_AUX_DLY_CFG2 = 6'h19;
  localparam logic [5:0] ADDR_LOCK_CFG = 6'h1A;
  localparam logic [5:0] ADDR_OUT_PIN_CTRL = 6'h1B;
  localparam logic [5:0] ADDR_SLIP_CTRL = 6'h1C;
  localparam logic [5:0] ADDR_RSVD_A = 6'h1D;
  localparam logic [5:0] ADDR_TEMP_CTRL = 6'h1E;
  localparam logic [5:0] ADDR_STATUS = 6'h1F;
  localparam logic [5:0] ADDR_RSVD_B = 6'h20;
  localparam logic [5:0] ADDR_TEMP_READ = 6'h21;
  localparam logic [5:0] ADDR_RSVD_C = 6'h22;
  localparam logic [23:0] RST_AUX_DLY_CFG2 = 24'h00000F;
  localparam logic [23:0] RST_LOCK_CFG = 24'h001040;
  localparam logic [23:0] RST_OUT_PIN_CTRL = 24'h000000;
  localparam logic [23:0] RST_SLIP_CTRL = 24'h000020;
  localparam logic [23:0] RST_TEMP_CTRL = 24'h000000;
  localparam logic [23:0] RST_RSVD_A = 24'h000000;
  localparam logic [23:0] RST_RSVD_B = 24'h000020;
  localparam logic [23:0] RST_RSVD_C = 24'h000000;
  localparam logic [6:0] RST_TEMP_CODE = 7'h1F;
  localparam int POS_HIDLY = 0;
  localparam int POS_CLKINV = 3;
  localparam int POS_CLKWRING = 4;
  localparam int POS_LOCK_THR = 0;
  localparam int POS_AUTO_ROUTE = 12;
  localparam int POS_FORCE_ROUTE = 13;
  localparam int POS_OUT_SEL = 0;
  localparam int POS_STATIC_PAT = 4;
  localparam int POS_DRIVE_EN = 7;
  localparam int POS_PIN_DIS = 8;
  localparam int POS_SLIP_STEP = 0;
  localparam int POS_RST_OVERRIDE = 4;
  localparam int POS_RST_RELEASE = 5;
  localparam int POS_ST_LOCK = 0;
  localparam int POS_ST_OVF = 1;
  localparam int POS_ST_SWEEP = 5;
  localparam logic [6:0] TEMP_CODE_MAX = 7'h07;
  localparam int TEMP_OFFSET_C = 40;
  localparam int TEMP_STEP_TENTHS = 175;
  typedef enum logic [3:0] {
    SEL_STATIC = 4'h0, SEL_CLOCKS = 4'h1, SEL_DETECTOR = 4'h2, SEL_SATURATE = 4'h3,
    SEL_REFS = 4'h4, SEL_PHASE = 4'h6, SEL_AUXCLK = 4'h7, SEL_SWEEP = 4'h8,
    SEL_QUANT = 4'hA
  } fnrb_sel_type;
endpackage

// >>> fnrb_src_if.sv
// internal digital sources offered to the output pin selector
`timescale 1ns/1ps
interface fnrb_src_if;
  logic ext_ref_clk;
  logic div_ref_clk;
  logic div_osc_clk;
  logic det_up;
  logic detector_down_pulse;
  logic lock_window;
  logic sat_ref;
  logic sat_osc;
  logic gain_hold;
  logic ext_sine_ref;
  logic synced_fraction_strobe;
  logic [2:0] quantized_phase_bits;
  logic aux_clk;
  logic ring_test_clk;
  logic modulator_clock;
  logic sweep_active;
  logic [2:0] quant_lsbs;
  modport src (output ext_ref_clk, div_ref_clk, div_osc_clk, det_up, detector_down_pulse,
    lock_window, sat_ref, sat_osc, gain_hold, ext_sine_ref, synced_fraction_strobe,
    quantized_phase_bits, aux_clk, ring_test_clk, modulator_clock, sweep_active, quant_lsbs);
  modport sel (input ext_ref_clk, div_ref_clk, div_osc_clk, det_up, detector_down_pulse,
    lock_window, sat_ref, sat_osc, gain_hold, ext_sine_ref, synced_fraction_strobe,
    quantized_phase_bits, aux_clk, ring_test_clk, modulator_clock, sweep_active, quant_lsbs);
endinterface

// >>> fnrb_pin_mux.sv
// selector that routes internal sources onto the three output pins
`timescale 1ns/1ps
module fnrb_pin_mux
  import fnrb_pkg::*;
(
  // control
  input wire logic [3:0] sel_i,
  input wire logic [2:0] static_pat_i,
  // sources
  fnrb_src_if.sel src,
  // pin levels, pin three in bit 2
  output logic [2:0] pins_o
);
  always_comb begin
    case (sel_i)
      SEL_STATIC: pins_o = static_pat_i;
      SEL_CLOCKS: pins_o = {src.ext_ref_clk, src.div_ref_clk, src.div_osc_clk};
      SEL_DETECTOR: pins_o = {src.det_up, src.detector_down_pulse, src.lock_window};
      SEL_SATURATE: pins_o = {src.sat_ref, src.sat_osc, src.gain_hold};
      SEL_REFS: pins_o = {src.ext_ref_clk, src.ext_sine_ref, src.synced_fraction_strobe};
      // bit 0 of the phase word goes to pin three, bit 2 to pin one
      SEL_PHASE: pins_o = {src.quantized_phase_bits[0], src.quantized_phase_bits[1],
        src.quantized_phase_bits[2]};
      SEL_AUXCLK: pins_o = {src.aux_clk, src.ring_test_clk, src.modulator_clock};
      // pin one has no function here; held low
      SEL_SWEEP: pins_o = {1'b0, src.sweep_active, 1'b0};
      SEL_QUANT: pins_o = src.quant_lsbs;
      default: pins_o = 3'h0;
    endcase
  end
endmodule

// >>> fnrb_top.sv
// register bank: output pin routing, lock detect, slip prevention and status
//
// Behaviour
// - select 0000 drives static pattern onto pins
// - select 0001 routes three reference/oscillator clocks
// - select 0010 routes detector pulses and window
// - select 0011 routes saturation signals and gain strobe
// - select 0100 routes references and fraction strobe
// - select 0110 shows quantized oscillator phase bits
// - select 0111 routes auxiliary, ring, modulator clocks
// - select 1000 pin three low, pin two sweep
// - select 1010 shows quantizer three low bits
// - pads driven only with drive-enable bit set
// - per-pin disable bits turn off single drivers
// - lock when window count reaches threshold
// - auto-route puts lock on idle serial output
// - forced-route keeps lock on serial output always
// - status bit 0 reports locked state
// - status bits three..one report modulator overflow
// - status bit 5 reports sweep in progress
// - temperature code floor((t+40)/17.5), saturated 0..7
// - zero slip step disables slip prevention
// - override bit lets release bit drive detector reset
// - release bit plus config enable enables prevention
// - high delay field feeds square-wave modulation
// - clock-invert bit inverts auxiliary clock for modulator
`timescale 1ns/1ps
module fnrb_top
  import fnrb_pkg::*;
#(
  parameter int THR_W = 10,
  parameter int OVF_W = 3
)(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port from the main serial interface
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  // serial data output path
  input wire logic serial_read_busy_i,
  input wire logic serial_read_bit_i,
  output logic serial_data_o,
  // lock detect window events
  input wire logic ref_cycle_in_window_i,
  input wire logic window_restart_i,
  // status sources
  input wire logic [OVF_W-1:0] overflow_i,
  input wire logic sweep_active_i,
  input wire logic signed [9:0] temp_c_i,
  // slip prevention hooks
  input wire logic slip_cfg_enable_i,
  input wire logic slip_auto_rstb_i,
  output logic det_rst_n_o,
  output logic slip_enable_o,
  output logic slip_advance_o,
  output logic [2:0] slip_cycles_o,
  // delay modulator
  input wire logic aux_clk_i,
  output logic [2:0] mod_high_delay_o,
  output logic mod_aux_clk_o,
  // raw sources for the output pins
  input wire logic [2:0] clk_src_i,
  input wire logic [2:0] det_src_i,
  input wire logic [2:0] sat_src_i,
  input wire logic [1:0] ref_src_i,
  input wire logic [2:0] phase_bits_i,
  input wire logic [1:0] aux_src_i,
  input wire logic modulator_clock_i,
  input wire logic [2:0] quant_lsbs_i,
  // output pins, bit 0 is general_output_pin_one
  output logic [2:0] gpo_o,
  output logic [2:0] gpo_oe_o
);
  logic [23:0] aux_cfg;
  logic [23:0] lock_cfg;
  logic [23:0] pin_ctrl;
  logic [23:0] slip_ctrl;
  logic [23:0] temp_ctrl;
  logic [THR_W-1:0] win_count;
  logic locked;
  logic [6:0] temp_code;
  logic [2:0] sweep_sync;
  logic sweep_flag;
  logic [2:0] pin_level;
  logic [2:0] ovf_flags;

  // decode
  wire wr_aux = wr_i && (addr_i == ADDR_AUX_DLY_CFG2);
  wire wr_lock = wr_i && (addr_i == ADDR_LOCK_CFG);
  wire wr_pin = wr_i && (addr_i == ADDR_OUT_PIN_CTRL);
  wire wr_slip = wr_i && (addr_i == ADDR_SLIP_CTRL);
  wire wr_temp = wr_i && (addr_i == ADDR_TEMP_CTRL);
  wire [THR_W-1:0] lock_thr = lock_cfg[POS_LOCK_THR +: THR_W];
  wire lock_to_serial_out_auto = lock_cfg[POS_AUTO_ROUTE];
  wire lock_to_serial_out_forced = lock_cfg[POS_FORCE_ROUTE];
  wire [3:0] out_sel = pin_ctrl[POS_OUT_SEL +: 4];
  wire [2:0] static_pat = pin_ctrl[POS_STATIC_PAT +: 3];
  wire drive_en = pin_ctrl[POS_DRIVE_EN];
  wire [2:0] pin_dis = pin_ctrl[POS_PIN_DIS +: 3];
  wire [3:0] slip_prevention_phase_step = slip_ctrl[POS_SLIP_STEP +: 4];
  wire rst_override = slip_ctrl[POS_RST_OVERRIDE];
  wire rst_release = slip_ctrl[POS_RST_RELEASE];
  wire [23:0] status_word = {18'h0, sweep_flag, 1'b0, ovf_flags, locked};
  wire [6:0] next_temp_code;
  wire [23:0] read_mux;

  // registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_cfg <= RST_AUX_DLY_CFG2;
      lock_cfg <= RST_LOCK_CFG;
      pin_ctrl <= RST_OUT_PIN_CTRL;
      slip_ctrl <= RST_SLIP_CTRL;
      temp_ctrl <= RST_TEMP_CTRL;
    end else begin
      if (wr_aux) begin
        aux_cfg <= {19'h0, wdata_i[4:0]};
      end
      if (wr_lock) begin
        lock_cfg <= {4'h0, wdata_i[19:0]};
      end
      if (wr_pin) begin
        pin_ctrl <= {13'h0, wdata_i[10:0]};
      end
      if (wr_slip) begin
        slip_ctrl <= {18'h0, wdata_i[5:0]};
      end
      if (wr_temp) begin
        temp_ctrl <= {23'h0, wdata_i[0]};
      end
    end
  end

  // lock detect: count reference cycles inside the window; restart clears
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      win_count <= '0;
      locked <= 1'b0;
    end else if (window_restart_i) begin
      win_count <= '0;
      locked <= 1'b0;
    end else if (ref_cycle_in_window_i) begin
      if (win_count != {THR_W{1'b1}}) begin
        win_count <= win_count + 1'b1;
      end
      if ((win_count + 1'b1) >= lock_thr) begin
        locked <= 1'b1;
      end
    end
  end

  // sweep flag comes from another block's clock region; three-stage filter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sweep_sync <= 3'h0;
      sweep_flag <= 1'b0;
    end else begin
      sweep_sync <= {sweep_sync[1:0], sweep_active_i};
      if (sweep_sync[2] == sweep_sync[1]) begin
        sweep_flag <= sweep_sync[2];
      end
    end
  end

  // temperature: code = floor((t+40)*10/175), saturated
  wire signed [15:0] temp_scaled = (16'(signed'(temp_c_i)) + 16'(TEMP_OFFSET_C)) * 16'sd10;
  wire signed [15:0] temp_quot = temp_scaled / 16'(TEMP_STEP_TENTHS);
  assign next_temp_code = (temp_scaled <= 16'sd0) ? 7'h00 :
    (temp_quot >= 16'(TEMP_CODE_MAX)) ? TEMP_CODE_MAX : 7'(temp_quot);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      temp_code <= RST_TEMP_CODE;
      ovf_flags <= 3'h0;
    end else begin
      temp_code <= next_temp_code;
      ovf_flags <= overflow_i;
    end
  end

  // read path
  assign read_mux =
    (addr_i == ADDR_AUX_DLY_CFG2) ? aux_cfg :
    (addr_i == ADDR_LOCK_CFG) ? lock_cfg :
    (addr_i == ADDR_OUT_PIN_CTRL) ? pin_ctrl :
    (addr_i == ADDR_SLIP_CTRL) ? slip_ctrl :
    (addr_i == ADDR_RSVD_A) ? RST_RSVD_A :
    (addr_i == ADDR_TEMP_CTRL) ? temp_ctrl :
    (addr_i == ADDR_STATUS) ? status_word :
    (addr_i == ADDR_RSVD_B) ? RST_RSVD_B :
    (addr_i == ADDR_TEMP_READ) ? {17'h0, temp_code} :
    (addr_i == ADDR_RSVD_C) ? RST_RSVD_C : 24'h000000;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 24'h000000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= read_mux;
      end
    end
  end

  // serial data out: forced route wins; reads would be lost, host must not read then
  wire next_serial = lock_to_serial_out_forced ? locked :
    serial_read_busy_i ? serial_read_bit_i :
    lock_to_serial_out_auto ? locked : 1'b0;

  // slip prevention and detector reset
  wire next_slip_en = (slip_prevention_phase_step != 4'h0) && rst_release
    && slip_cfg_enable_i;
  wire next_det_rst_n = rst_override ? rst_release : slip_auto_rstb_i;

  // output pin selection
  fnrb_src_if srcs ();
  assign srcs.ext_ref_clk = clk_src_i[2];
  assign srcs.div_ref_clk = clk_src_i[1];
  assign srcs.div_osc_clk = clk_src_i[0];
  assign srcs.det_up = det_src_i[2];
  assign srcs.detector_down_pulse = det_src_i[1];
  assign srcs.lock_window = det_src_i[0];
  assign srcs.sat_ref = sat_src_i[2];
  assign srcs.sat_osc = sat_src_i[1];
  assign srcs.gain_hold = sat_src_i[0];
  assign srcs.ext_sine_ref = ref_src_i[1];
  assign srcs.synced_fraction_strobe = ref_src_i[0];
  assign srcs.quantized_phase_bits = phase_bits_i;
  assign srcs.aux_clk = aux_src_i[1];
  assign srcs.ring_test_clk = aux_src_i[0];
  assign srcs.modulator_clock = modulator_clock_i;
  assign srcs.sweep_active = sweep_flag;
  assign srcs.quant_lsbs = quant_lsbs_i;

  fnrb_pin_mux u_mux (
    .sel_i(out_sel),
    .static_pat_i(static_pat),
    .src(srcs),
    .pins_o(pin_level)
  );

  // outputs registered; routed clocks are therefore sampled at mclk rate
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gpo_o <= 3'h0;
      gpo_oe_o <= 3'h0;
      serial_data_o <= 1'b0;
      det_rst_n_o <= 1'b1;
      slip_enable_o <= 1'b0;
      slip_advance_o <= 1'b0;
      slip_cycles_o <= 3'h0;
      mod_high_delay_o <= 3'h7;
      mod_aux_clk_o <= 1'b0;
    end else begin
      gpo_o <= pin_level;
      gpo_oe_o <= {3{drive_en}} & ~pin_dis;
      serial_data_o <= next_serial;
      det_rst_n_o <= next_det_rst_n;
      slip_enable_o <= next_slip_en;
      slip_advance_o <= slip_prevention_phase_step[3];
      slip_cycles_o <= slip_prevention_phase_step[2:0];
      mod_high_delay_o <= aux_cfg[POS_HIDLY +: 3];
      mod_aux_clk_o <= aux_clk_i ^ aux_cfg[POS_CLKINV];
    end
  end

  // assertions
  property p_pad_enable;
    @(posedge mclk_i) disable iff (rst_i)
      !$past(drive_en) |-> gpo_oe_o == 3'h0;
  endproperty
  a_pad_enable: assert property (p_pad_enable) else $error("pad driven while disabled");

  property p_pin_disable;
    @(posedge mclk_i) disable iff (rst_i)
      $past(drive_en) |-> gpo_oe_o == ~$past(pin_dis);
  endproperty
  a_pin_disable: assert property (p_pin_disable) else $error("pin disable mismatch");

  property p_static;
    @(posedge mclk_i) disable iff (rst_i)
      $past(out_sel) == 4'h0 |-> gpo_o == $past(static_pat);
  endproperty
  a_static: assert property (p_static) else $error("static pattern not on pins");

  property p_reserved_low;
    @(posedge mclk_i) disable iff (rst_i)
      ($past(out_sel) == 4'h5 || $past(out_sel) > 4'hA || $past(out_sel) == 4'h9)
      |-> gpo_o == 3'h0;
  endproperty
  a_reserved_low: assert property (p_reserved_low) else $error("reserved select not low");

  property p_forced;
    @(posedge mclk_i) disable iff (rst_i)
      $past(lock_to_serial_out_forced) |-> serial_data_o == $past(locked);
  endproperty
  a_forced: assert property (p_forced) else $error("forced lock route broken");

  property p_auto;
    @(posedge mclk_i) disable iff (rst_i)
      ($past(lock_to_serial_out_auto) && !$past(serial_read_busy_i)) |-> serial_data_o == $past(locked);
  endproperty
  a_auto: assert property (p_auto) else $error("auto lock route broken");

  property p_lock;
    @(posedge mclk_i) disable iff (rst_i)
      (win_count >= lock_thr && lock_thr != '0 && !window_restart_i) |=> locked;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not declared at threshold");

  property p_status;
    @(posedge mclk_i) disable iff (rst_i)
      rd_i && addr_i == ADDR_STATUS |=> rdata_o[0] == $past(locked)
        && rdata_o[3:1] == $past(ovf_flags) && rdata_o[5] == $past(sweep_flag);
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");

  property p_slip_zero;
    @(posedge mclk_i) disable iff (rst_i)
      $past(slip_prevention_phase_step) == 4'h0 |-> !slip_enable_o;
  endproperty
  a_slip_zero: assert property (p_slip_zero) else $error("slip enabled at zero");

  property p_override;
    @(posedge mclk_i) disable iff (rst_i)
      $past(rst_override) |-> det_rst_n_o == $past(rst_release);
  endproperty
  a_override: assert property (p_override) else $error("reset override ignored");

  property p_temp_sat;
    @(posedge mclk_i) disable iff (rst_i)
      temp_c_i >= 10'sd83 |=> temp_code == TEMP_CODE_MAX;
  endproperty
  a_temp_sat: assert property (p_temp_sat) else $error("temperature not saturated");

  c_lock: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(locked));
  c_gpo_on: cover property (@(posedge mclk_i) disable iff (rst_i) gpo_oe_o == 3'h7);
  c_sweep: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(sweep_flag));
  c_forced: cover property (@(posedge mclk_i) disable iff (rst_i) lock_to_serial_out_forced);
endmodule

// >>> fnrb_board_model.sv
// board model: pull-down resistors on the three general output pins
`timescale 1ns/1ps
module fnrb_board_model (
  // pad drive from the device
  input wire logic [2:0] gpo_i,
  input wire logic [2:0] oe_i,
  // level seen on the board
  output logic [2:0] pad_o
);
  // a pad left undriven settles low through its pull-down, never at the last value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad_o[i] = oe_i[i] ? gpo_i[i] : 1'h0;
    end
  end
endmodule

// >>> test_output_mux_lock_status_regs.sv
// self-checking bench for the register bank and output pin routing
`timescale 1ns/1ps
module test_output_mux_lock_status_regs;
  import fnrb_pkg::*;
  logic mclk_i = 0;
  logic rst_i = 1;
  logic wr_i = 0;
  logic rd_i = 0;
  logic [5:0] addr_i = '0;
  logic [23:0] wdata_i = '0;
  logic [23:0] rdata_o;
  logic rvalid_o;
  logic busy = 0, sbit = 0, sdo;
  logic win = 0, wrst = 0, sweep = 0, cfg_en = 0, auto_rstb = 0, aux = 0, mclk_s = 0;
  logic [2:0] ovf = 0, clk_s = 0, det_s = 0, sat_s = 0, ph = 0, ql = 0;
  logic [1:0] ref_s = 0, aux_s = 0;
  logic signed [9:0] temp = 0;
  logic det_rst_n, slip_en, slip_adv, maux;
  logic [2:0] slip_cyc, hdly, gpo, oe, pad, p, dis;
  logic [3:0] s;
  logic en;
  logic [23:0] v, w;
  int t;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [5:0] ra [9] = '{6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1F, 6'h20, 6'h22, 6'h00};
  logic [23:0] rv [9] = '{24'h00000F, 24'h001040, 24'h0, 24'h000020, 24'h0, 24'h0,
    24'h000020, 24'h0, 24'h0};
  int tt [8] = '{-60, -40, -23, -22, 0, 82, 83, 200};

  fnrb_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .serial_read_busy_i(busy),
    .serial_read_bit_i(sbit), .serial_data_o(sdo), .ref_cycle_in_window_i(win),
    .window_restart_i(wrst), .overflow_i(ovf), .sweep_active_i(sweep), .temp_c_i(temp),
    .slip_cfg_enable_i(cfg_en), .slip_auto_rstb_i(auto_rstb), .det_rst_n_o(det_rst_n),
    .slip_enable_o(slip_en), .slip_advance_o(slip_adv), .slip_cycles_o(slip_cyc),
    .aux_clk_i(aux), .mod_high_delay_o(hdly), .mod_aux_clk_o(maux), .clk_src_i(clk_s),
    .det_src_i(det_s), .sat_src_i(sat_s), .ref_src_i(ref_s), .phase_bits_i(ph),
    .aux_src_i(aux_s), .modulator_clock_i(mclk_s), .quant_lsbs_i(ql), .gpo_o(gpo),
    .gpo_oe_o(oe));
  fnrb_board_model board (.gpo_i(gpo), .oe_i(oe), .pad_o(pad));

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [23:0] d);
    wr_i = 1;
    addr_i = a;
    wdata_i = d;
    cyc(1);
    wr_i = 0;
    // one idle edge so a following call never raises the strobe it just lowered
    cyc(1);
  endtask

  // read valid stands for one cycle only, so it and the held answer are taken right after the read edge
  task automatic reg_rd(input logic [5:0] a, output logic [23:0] d);
    rd_i = 1;
    addr_i = a;
    cyc(1);
    rd_i = 0;
    check("rvalid", rvalid_o, 24'h1);
    d = rdata_o;
    cyc(1);
  endtask

  function automatic logic [2:0] pin_exp(input logic [3:0] sl, input logic [2:0] pat);
    case (sl)
      4'h0: pin_exp = pat;
      4'h1: pin_exp = clk_s;
      4'h2: pin_exp = det_s;
      4'h3: pin_exp = sat_s;
      4'h4: pin_exp = {clk_s[2], ref_s};
      4'h6: pin_exp = {ph[0], ph[1], ph[2]};
      4'h7: pin_exp = {aux_s, mclk_s};
      4'h8: pin_exp = {1'h0, sweep, 1'h0};
      4'hA: pin_exp = ql;
      default: pin_exp = 3'h0;
    endcase
  endfunction

  function automatic logic [6:0] temp_exp(input int tc);
    int q;
    q = (tc + 40) * 10;
    if (q < 0) begin
      q = 0;
    end
    q = q / 175;
    if (q > 7) begin
      q = 7;
    end
    return 7'(q);
  endfunction

  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end

  initial begin
    v = $urandom(32'hE24B8F09);
    cyc(2);
    rst_i = 0;
    check("hidly rst", hdly, 24'h7);
    // the modulator clock output is low in reset and takes the inverted clock one edge later
    cyc(1);
    check("auxclk rst", maux, 24'h1);
    // writes to read-only places must leave them untouched
    reg_wr(6'h1D, 24'hFFFFFF);
    reg_wr(6'h1F, 24'hFFFFFF);
    reg_wr(6'h20, 24'hFFFFFF);
    reg_wr(6'h22, 24'hFFFFFF);
    foreach (ra[i]) begin
      reg_rd(ra[i], v);
      check("reset value", v, rv[i]);
    end
    for (int i = 0; i < 40; i++) begin
      s = (i < 16) ? 4'(i) : 4'($urandom);
      p = 3'($urandom);
      en = (i < 16) ? 1'h1 : 1'($urandom);
      dis = (i < 16) ? 3'h0 : 3'($urandom);
      {clk_s, det_s, sat_s, ph, ql} = 15'($urandom);
      {ref_s, aux_s, mclk_s, sweep} = 6'($urandom);
      reg_wr(6'h1B, {13'h0, dis, en, p, s});
      // sweep input passes a synchroniser, so give it time to settle
      cyc(5);
      check("gpo", gpo, pin_exp(s, p));
      check("gpo_oe", oe, 3'(en ? ~dis : 3'h0));
      check("pad", pad, 3'(en ? (~dis & pin_exp(s, p)) : 3'h0));
      reg_rd(6'h1B, v);
      check("pin ctrl", v, {13'h0, dis, en, p, s});
    end
    reg_wr(6'h1A, 24'h001003);
    wrst = 1;
    cyc(1);
    wrst = 0;
    for (int i = 1; i <= 4; i++) begin
      win = 1;
      cyc(1);
      win = 0;
      cyc(3);
      reg_rd(6'h1F, v);
      check("lock", v[0], 24'(i >= 3));
      check("sdo auto", sdo, 24'(i >= 3));
    end
    busy = 1;
    cyc(3);
    check("sdo read", sdo, 24'h0);
    sbit = 1;
    cyc(3);
    check("sdo read", sdo, 24'h1);
    sbit = 0;
    reg_wr(6'h1A, 24'h003003);
    cyc(3);
    check("sdo forced", sdo, 24'h1);
    wrst = 1;
    cyc(1);
    wrst = 0;
    cyc(3);
    check("sdo unlock", sdo, 24'h0);
    busy = 0;
    reg_wr(6'h1A, 24'h001003);
    for (int i = 0; i < 4; i++) begin
      ovf = 3'($urandom);
      sweep = 1'($urandom);
      cyc(5);
      reg_rd(6'h1F, v);
      check("status", v, {18'h0, sweep, 1'h0, ovf, 1'h0});
    end
    for (int i = 0; i < 12; i++) begin
      t = (i < 8) ? tt[i] : int'($urandom_range(300)) - 100;
      temp = 10'(t);
      cyc(2);
      reg_rd(6'h21, v);
      check("temp code", v, {17'h0, temp_exp(t)});
    end
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 24'h000020 : 24'($urandom) & 24'h00003F;
      cfg_en = (i == 0) ? 1'h1 : 1'($urandom);
      auto_rstb = 1'($urandom);
      reg_wr(6'h1C, w);
      cyc(3);
      check("det_rst_n", det_rst_n, w[4] ? w[5] : auto_rstb);
      check("slip_en", slip_en, w[5] & cfg_en & (w[3:0] != 4'h0));
      check("slip step", {slip_adv, slip_cyc}, w[3:0]);
      reg_rd(6'h1C, v);
      check("slip ctrl", v, w);
    end
    for (int i = 0; i < 6; i++) begin
      w = 24'($urandom) & 24'h00001F;
      aux = 1'($urandom);
      reg_wr(6'h19, w);
      cyc(3);
      check("hidly", hdly, w[2:0]);
      check("auxclk", maux, aux ^ w[3]);
      reg_rd(6'h19, v);
      check("aux cfg", v, w);
    end
    test_done();
  end
endmodule
